// ===== hw/flash_front_pkg.sv
// Package with the constants, opcodes and types of the serial flash command front end.
// Notes on behaviour
// - Program or erase commands are discarded while write protect is low.
// - A discarded protected command returns to idle when chip select rises.
// - Enable-protection and sector-lockdown commands still execute under write protect.
// - Reset pin low aborts the operation and returns the command machine to idle.
// - The device stays in reset while the reset pin is low.
// - Power-on reset initialises the machine without pin sequencing.
// - Instruction starts at chip select fall, then 8-bit opcode, then address.
// - Opcode, address and data travel most significant bit first.
// - Address is three bytes of dummy bits plus real address bits.
// - 528-byte pages use a 10-bit buffer byte address.
// - 528-byte pages use 12-bit page plus 10-bit byte offset.
// - 512-byte pages use a nine-bit buffer byte address.
// - 512-byte pages use a linear 21-bit address, page in upper 12 bits.
// - Legacy read is opcode, three address bytes, four dummies, then data out.
// - Internal address counter advances automatically during continuous read.
// - End of page continues at next page start with no waits.
// - End of array wraps to the first page with no delay.
// - Chip select rising ends the read and floats the serial output.
// - Continuous read bypasses both buffers and leaves them unchanged.
// - Inputs sampled on rising serial clock, outputs launched on falling edge.
// - With chip select high, input is ignored and output floats.
package flash_front_pkg;

   // -----------------------------------------------------------------
   // Opcodes
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_LEGACY_READ = 8'hE8;
   localparam logic [7:0] OP_PROT_ENABLE_PRE = 8'h3D;
   localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
   localparam logic [7:0] OP_BUF1_PROGRAM = 8'h83;
   localparam logic [7:0] OP_BUF2_PROGRAM = 8'h86;
   localparam logic [7:0] OP_BYTE_PROGRAM = 8'h02;
   localparam logic [7:0] OP_MEM_PROG_BUF1 = 8'h82;
   localparam logic [7:0] OP_MEM_PROG_BUF2 = 8'h85;

   // -----------------------------------------------------------------
   // Geometry and counts
   // -----------------------------------------------------------------
   localparam int OPCODE_BITS = 8;
   localparam int ADDR_BYTES = 3;
   localparam int DUMMY_BYTES = 4;
   localparam logic [5:0] ADDR_BIT_COUNT = 6'h18;
   localparam logic [5:0] DUMMY_BIT_COUNT = 6'h20;
   localparam logic [3:0] OPCODE_BIT_COUNT = 4'h8;
   localparam logic [11:0] LAST_PAGE = 12'hFFF;
   localparam logic [9:0] LAST_BYTE_STD = 10'h20F;
   localparam logic [9:0] LAST_BYTE_BIN = 10'h1FF;
   localparam int PAGE_BITS = 12;
   localparam int BYTE_BITS_STD = 10;
   localparam int BYTE_BITS_BIN = 9;
   localparam int BUF_DEPTH = 2;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [23:0] ADDR_RESET = 24'h000000;

   // Command phases, one-hot.
   typedef enum logic [5:0] {
      PH_IDLE = 6'b000001,
      PH_OPCODE = 6'b000010,
      PH_ADDR = 6'b000100,
      PH_DUMMY = 6'b001000,
      PH_DATA = 6'b010000,
      PH_IGNORE = 6'b100000
   } phase_t;

   // Page selection and byte offset of the read pointer.
   typedef struct packed {
      logic [11:0] page;
      logic [9:0] offset;
   } array_ptr_t;

   // Returns true for program and erase opcodes that write protect gates.
   function automatic logic is_modify_op(input logic [7:0] op);
      return (op == OP_PAGE_ERASE) || (op == OP_BLOCK_ERASE) || (op == OP_SECTOR_ERASE) ||
         (op == OP_BUF1_PROGRAM) || (op == OP_BUF2_PROGRAM) || (op == OP_BYTE_PROGRAM) ||
         (op == OP_MEM_PROG_BUF1) || (op == OP_MEM_PROG_BUF2);
   endfunction

   // Splits a three-byte address into page and offset by page size.
   function automatic array_ptr_t split_addr(input logic [23:0] a, input logic bin_size);
      array_ptr_t p;
      p.page = bin_size ? a[20:9] : a[21:10];
      p.offset = bin_size ? {1'b0, a[8:0]} : a[9:0];
      return p;
   endfunction

endpackage

// ===== hw/byte_stream_if.sv
// Interface that carries read bytes from the sequencer into the output buffer.
`timescale 1ns/1ps
interface byte_stream_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface

// ===== hw/byte_skid_buffer.sv
// Two-entry buffer between the array fetch and the serial shifter.
`timescale 1ns/1ps
module byte_skid_buffer
   import flash_front_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic flush_i,
   // Filling side
   byte_stream_if.dst in_s,
   // Draining side
   output logic out_valid_o,
   output logic [7:0] out_data_o,
   input wire logic out_ready_i
);

   typedef struct packed {
      logic [1:0][7:0] mem;
      logic rd;
      logic wr;
      logic [1:0] cnt;
   } buf_t;

   buf_t s_reg;
   buf_t s_next;
   logic push;
   logic pop;

   // Handshakes on both sides; full stalls the filler honestly.
   assign in_s.ready = (s_reg.cnt != 2'h2);
   assign out_valid_o = (s_reg.cnt != 2'h0);
   assign out_data_o = s_reg.mem[s_reg.rd];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_valid_o && out_ready_i;

   // Next state of pointers and storage; a flush empties it at frame end.
   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wr] = in_s.data;
         s_next.wr = ~s_reg.wr;
      end
      if (pop) begin
         s_next.rd = ~s_reg.rd;
      end
      s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};
      if (flush_i) begin
         s_next.rd = 1'b0;
         s_next.wr = 1'b0;
         s_next.cnt = 2'h0;
      end
   end

   // State register.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   a_buf_no_over: assert property (@(posedge clk_i) disable iff (rst_i)
      s_reg.cnt <= 2'h2) else $error("Buffer count exceeds two entries.");

endmodule

// ===== hw/flash_cmd_front_end.sv
// Command front end of a serial flash: framing, decoding, write protect and legacy read.
`timescale 1ns/1ps
module flash_cmd_front_end
   import flash_front_pkg::*;
(
   // System clock and reset
   input wire logic MCLK_I,
   input wire logic RST_I,
   // Serial link pins
   input wire logic CS_N_I,
   input wire logic SCK_I,
   input wire logic SI_I,
   output logic SO_O,
   output logic SO_OE_O,
   // Control pins
   input wire logic WP_N_I,
   input wire logic RESET_N_I,
   input wire logic PAGE_BIN_I,
   // Array read port
   output logic [11:0] ARR_PAGE_O,
   output logic [9:0] ARR_OFFSET_O,
   output logic ARR_REQ_O,
   input wire logic [7:0] ARR_DATA_I,
   // Command results
   output logic [7:0] CMD_OP_O,
   output logic [23:0] CMD_ADDR_O,
   output logic CMD_START_O,
   output logic CMD_BLOCKED_O
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic sck_d;
   } sync_t;

   sync_t y_reg;
   sync_t y_next;
   logic cs_n;
   logic sck;
   logic si;
   logic wp_n;
   logic rst_pin_n;
   logic page_bin;
   logic sck_rise;
   logic sck_fall;

   // Two flops per pin; the second stage is looked at, plus a third flop on the serial clock for edge detection.
   always_comb begin
      // The page-size pin is a pin like the others, so it is synchronised too.
      y_next.s1 = {CS_N_I, SCK_I, SI_I, WP_N_I, RESET_N_I, PAGE_BIN_I};
      y_next.s2 = y_reg.s1;
      y_next.sck_d = y_reg.s2[4];
   end

   // Synchroniser register; chip select and pin reset rest inactive.
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         y_reg <= 13'h134C;
      end else begin
         y_reg <= y_next;
      end
   end

   assign {cs_n, sck, si, wp_n, rst_pin_n, page_bin} = y_reg.s2;
   // Rising edge samples input and falling edge launches output.
   assign sck_rise = sck && !y_reg.sck_d;
   assign sck_fall = !sck && y_reg.sck_d;

   // ----------------------------------------------------------------
   // Command state
   // ----------------------------------------------------------------
   typedef struct packed {
      phase_t ph;
      logic [7:0] sh;
      logic [5:0] cnt;
      logic [7:0] op;
      logic [23:0] addr;
      array_ptr_t ptr;
      logic req;
      logic [7:0] obyte;
      logic [2:0] obit;
      logic ohave;
      logic so;
      logic oe;
      logic start;
      logic blocked;
   } cmd_t;

   cmd_t c_reg;
   cmd_t c_next;
   logic in_ready;
   logic out_valid;
   logic [7:0] out_data;
   logic out_ready;
   logic flush;

   byte_stream_if fetch_s ();

   // The buffer holds fetched bytes so a late shifter loses none.
   byte_skid_buffer u_buf (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .flush_i(flush),
      .in_s(fetch_s.dst),
      .out_valid_o(out_valid),
      .out_data_o(out_data),
      .out_ready_i(out_ready)
   );

   assign in_ready = fetch_s.ready;
   assign fetch_s.valid = c_reg.req;
   assign fetch_s.data = ARR_DATA_I;
   assign flush = (c_reg.ph != PH_DATA);
   assign out_ready = (c_reg.ph == PH_DATA) && !c_reg.ohave;

   // Advances a pointer to the next byte, across pages and the array end.
   function automatic array_ptr_t next_ptr(input array_ptr_t p, input logic bin);
      array_ptr_t n;
      logic [9:0] last;
      last = bin ? LAST_BYTE_BIN : LAST_BYTE_STD;
      n = p;
      if (p.offset == last) begin
         n.offset = 10'h000;
         n.page = (p.page == LAST_PAGE) ? 12'h000 : p.page + 12'h001;
      end else begin
         n.offset = p.offset + 10'h001;
      end
      return n;
   endfunction

   // Command sequencing; the pin reset overrides everything while low.
   always_comb begin
      c_next = c_reg;
      c_next.start = 1'b0;
      c_next.req = c_reg.req && !in_ready;
      if (!rst_pin_n) begin
         c_next = '0;
         c_next.ph = PH_IDLE;
      end else if (cs_n) begin
         c_next.ph = PH_IDLE;
         c_next.oe = 1'b0;
         c_next.so = 1'b0;
         c_next.ohave = 1'b0;
         c_next.req = 1'b0;
      end else begin
         case (c_reg.ph)
            PH_IDLE: begin
               // Falling chip select opens a fresh frame.
               c_next.ph = PH_OPCODE;
               c_next.cnt = 6'h00;
               c_next.blocked = 1'b0;
            end
            PH_OPCODE: begin
               if (sck_rise) begin
                  c_next.sh = {c_reg.sh[6:0], si};
                  c_next.cnt = c_reg.cnt + 6'h01;
                  if (c_reg.cnt[3:0] == OPCODE_BIT_COUNT - 4'h1) begin
                     c_next.op = {c_reg.sh[6:0], si};
                     c_next.cnt = 6'h00;
                     // Protected modify commands are swallowed.
                     if (!wp_n && is_modify_op({c_reg.sh[6:0], si})) begin
                        c_next.ph = PH_IGNORE;
                        c_next.blocked = 1'b1;
                     end else begin
                        c_next.ph = PH_ADDR;
                     end
                  end
               end
            end
            PH_ADDR: begin
               if (sck_rise) begin
                  c_next.addr = {c_reg.addr[22:0], si};
                  c_next.cnt = c_reg.cnt + 6'h01;
                  if (c_reg.cnt == ADDR_BIT_COUNT - 6'h01) begin
                     c_next.cnt = 6'h00;
                     c_next.start = 1'b1;
                     // Page size picks the split of the address.
                     c_next.ptr = split_addr({c_reg.addr[22:0], si}, page_bin);
                     c_next.ph = (c_reg.op == OP_LEGACY_READ) ? PH_DUMMY : PH_IGNORE;
                  end
               end
            end
            PH_DUMMY: begin
               if (sck_rise) begin
                  c_next.cnt = c_reg.cnt + 6'h01;
                  if (c_reg.cnt == DUMMY_BIT_COUNT - 6'h01) begin
                     c_next.ph = PH_DATA;
                     c_next.req = 1'b1;
                  end
               end
            end
            PH_DATA: begin
               // Fetch from the array through the skid buffer only; no other buffer is touched.
               if (c_reg.req && in_ready) begin
                  c_next.ptr = next_ptr(c_reg.ptr, page_bin);
               end
               if (!c_reg.req && in_ready) begin
                  c_next.req = 1'b1;
               end
               if (out_valid && !c_reg.ohave) begin
                  c_next.obyte = out_data;
                  c_next.ohave = 1'b1;
                  c_next.obit = 3'h7;
               end
               if (sck_fall && c_reg.ohave) begin
                  c_next.so = c_reg.obyte[c_reg.obit];
                  c_next.oe = 1'b1;
                  c_next.obit = c_reg.obit - 3'h1;
                  if (c_reg.obit == 3'h0) begin
                     c_next.ohave = 1'b0;
                  end
               end
            end
            PH_IGNORE: begin
               c_next.ph = PH_IGNORE;
            end
            default: begin
               c_next.ph = PH_IDLE;
            end
         endcase
      end
   end

   // Command register; the system reset doubles as power-on reset.
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         c_reg <= '0;
         c_reg.ph <= PH_IDLE;
      end else begin
         c_reg <= c_next;
      end
   end

   // Outputs straight from flops.
   assign SO_O = c_reg.so;
   assign SO_OE_O = c_reg.oe;
   assign ARR_PAGE_O = c_reg.ptr.page;
   assign ARR_OFFSET_O = c_reg.ptr.offset;
   assign ARR_REQ_O = c_reg.req;
   assign CMD_OP_O = c_reg.op;
   assign CMD_ADDR_O = c_reg.addr;
   assign CMD_START_O = c_reg.start;
   assign CMD_BLOCKED_O = c_reg.blocked;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_cs_high;
      cs_n;
   endsequence

   a_wp_no_start: assert property (@(posedge MCLK_I) disable iff (RST_I)
      c_reg.blocked |-> !c_reg.start) else $error("Protected command started.");
   a_cs_floats_so: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_cs_high ##1 s_cs_high |=> !SO_OE_O) else $error("Output driven while deselected.");
   a_pin_reset_idle: assert property (@(posedge MCLK_I) disable iff (RST_I)
      !rst_pin_n |=> c_reg.ph == PH_IDLE) else $error("Pin reset left machine busy.");
   a_ignore_to_idle: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (c_reg.ph == PH_IGNORE) && cs_n && rst_pin_n |=> c_reg.ph == PH_IDLE)
      else $error("Ignored command did not return to idle.");
   a_read_wrap: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (c_reg.ph == PH_DATA) && c_reg.req && in_ready && (c_reg.ptr.page == LAST_PAGE) &&
      (c_reg.ptr.offset == (page_bin ? LAST_BYTE_BIN : LAST_BYTE_STD)) && !cs_n && rst_pin_n
      |=> c_reg.ptr.page == 12'h000 && c_reg.ptr.offset == 10'h000)
      else $error("Array end did not wrap.");
   a_so_on_fall: assert property (@(posedge MCLK_I) disable iff (RST_I)
      $changed(SO_O) && SO_OE_O && $past(SO_OE_O) |-> $past(sck_fall))
      else $error("Output changed off a falling clock.");
   a_addr_start: assert property (@(posedge MCLK_I) disable iff (RST_I)
      c_reg.start |-> $past(c_reg.ph == PH_ADDR) && $past(c_reg.cnt) == 6'h17)
      else $error("Start without a full address.");
   a_dummy_data: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (c_reg.ph == PH_DATA) && !$past(c_reg.ph == PH_DATA) |-> c_reg.op == OP_LEGACY_READ)
      else $error("Data phase without legacy read.");

   // A fetch that the buffer accepts while the read is still selected.
   sequence s_fetch;
      (c_reg.ph == PH_DATA) && c_reg.req && in_ready && !cs_n && rst_pin_n;
   endsequence

   // Only an unprotected or non-modifying opcode may go on to its address bytes.
   a_wp_gate: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (c_reg.ph == PH_ADDR) && ($past(c_reg.ph) == PH_OPCODE) |->
      $past(wp_n) || !is_modify_op(c_reg.op))
      else $error("Protected command reached the address phase.");
   a_block_needs_wp: assert property (@(posedge MCLK_I) disable iff (RST_I)
      $rose(c_reg.blocked) |-> !$past(wp_n))
      else $error("Command blocked without write protect.");
   a_oe_in_data: assert property (@(posedge MCLK_I) disable iff (RST_I)
      SO_OE_O |-> c_reg.ph == PH_DATA) else $error("Output enabled outside the data phase.");
   // The offset always moves on a fetch, to the next byte or back to zero.
   a_ptr_steps: assert property (@(posedge MCLK_I) disable iff (RST_I)
      s_fetch |=> ARR_OFFSET_O != $past(ARR_OFFSET_O))
      else $error("Read pointer did not advance.");
   a_cs_ends_read: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (c_reg.ph == PH_DATA) && cs_n |=> (c_reg.ph == PH_IDLE) && !SO_OE_O)
      else $error("Chip select rise did not end the read.");
   a_start_pulse: assert property (@(posedge MCLK_I) disable iff (RST_I)
      CMD_START_O |=> !CMD_START_O) else $error("Start pulse longer than one cycle.");

endmodule

// ===== verification/spi_host_model.sv
// Behavioural host controller that frames commands on the serial link.
`timescale 1ns/1ps
module spi_host_model (
   // Clock
   input wire logic clk_i,
   // Serial link
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_i
);
   // The link idles deselected with its clock parked low.
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
   end

   // One bit: launch on the fall, read back late in the high phase so slow answers still count.
   task automatic xfer_bit(input logic b, output logic r);
      @(posedge clk_i);
      sck_o <= 1'b0;
      si_o <= b;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      // A floating output has no pull, so it reads back as the inverse of the last value.
      r = so_oe_i ? so_i : ~so_i;
   endtask

   // A whole byte, most significant bit first in both directions.
   task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(tx[i], r);
         rx[i] = r;
      end
   endtask

   // Opening fall of chip select, then a settle time for the device's synchronisers.
   task automatic frame_begin();
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask

   // Opcode followed by the three address bytes.
   task automatic send_header(input logic [7:0] op, input logic [23:0] addr);
      logic [7:0] rx;
      xfer_byte(op, rx);
      for (int i = 2; i >= 0; i--) begin
         xfer_byte(addr[8*i+:8], rx);
      end
   endtask

   // Dummy bytes that prime a legacy read.
   // The legacy read is kept only to exercise the block; new host code should avoid it.
   task automatic send_dummies(input int n);
      logic [7:0] rx;
      repeat (n) xfer_byte(8'hA5, rx);
   endtask

   // Chip select was held low since the frame began; the released data line is inverted.
   task automatic frame_end();
      @(posedge clk_i);
      sck_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      cs_n_o <= 1'b1;
      si_o <= ~si_o;
      repeat (8) @(posedge clk_i);
   endtask
endmodule

// ===== verification/testbench.sv
// Self-checking testbench of the serial flash command front end.
`timescale 1ns/1ps
module testbench
   import flash_front_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic wp_n = 1'b1;
   logic reset_n = 1'b1;
   logic page_bin = 1'b0;
   logic cs_n, sck, si, so, so_oe, arr_req, cmd_start, cmd_blocked;
   logic [11:0] arr_page;
   logic [9:0] arr_offset;
   logic [7:0] arr_data, cmd_op;
   logic [23:0] cmd_addr;
   int n_fail = 0;
   int samples_checked = 0;
   int n_start = 0;

   // -----------------------------------------------------------------
   // Clock, array contents and instances
   // -----------------------------------------------------------------
   always #5 mclk = ~mclk;

   // Array byte pattern mixes page and offset so a missed crossover shows.
   function automatic logic [7:0] mem_byte(input logic [11:0] p, input logic [9:0] o);
      return p[7:0] ^ o[7:0] ^ {o[9:8], p[11:8], 2'h0};
   endfunction
   assign arr_data = mem_byte(arr_page, arr_offset);

   // Start pulses last one cycle, so they are counted as they pass.
   always @(posedge mclk) begin
      if (cmd_start === 1'b1) n_start <= n_start + 1;
   end

   flash_cmd_front_end u_dut (.MCLK_I(mclk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck),
      .SI_I(si), .SO_O(so), .SO_OE_O(so_oe), .WP_N_I(wp_n), .RESET_N_I(reset_n),
      .PAGE_BIN_I(page_bin), .ARR_PAGE_O(arr_page), .ARR_OFFSET_O(arr_offset),
      .ARR_REQ_O(arr_req), .ARR_DATA_I(arr_data), .CMD_OP_O(cmd_op), .CMD_ADDR_O(cmd_addr),
      .CMD_START_O(cmd_start), .CMD_BLOCKED_O(cmd_blocked));

   spi_host_model u_host (.clk_i(mclk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so),
      .so_oe_i(so_oe));

   // -----------------------------------------------------------------
   // Checking and closing
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   // Legacy read from a start point; the pointer model steps pages and wraps the array.
   task automatic read_check(input logic [11:0] pg, input logic [9:0] off, input logic bin,
      input int nbytes);
      logic [23:0] addr;
      logic [9:0] last;
      logic [7:0] rx;
      int starts;
      addr = bin ? {3'h7, pg, off[8:0]} : {2'h3, pg, off};
      last = bin ? LAST_BYTE_BIN : LAST_BYTE_STD;
      starts = n_start;
      @(posedge mclk);
      page_bin <= bin;
      u_host.frame_begin();
      u_host.send_header(OP_LEGACY_READ, addr);
      u_host.send_dummies(DUMMY_BYTES);
      for (int k = 0; k < nbytes; k++) begin
         u_host.xfer_byte(8'h00, rx);
         check(rx, mem_byte(pg, off), "read data");
         if (off == last) begin
            off = 10'h000;
            pg = pg + 12'h001;
         end else begin
            off = off + 10'h001;
         end
      end
      check(so_oe, 1'b1, "output enable in data");
      check(cmd_op, OP_LEGACY_READ, "opcode");
      check(cmd_addr, addr, "address");
      check(n_start - starts, 1, "start count");
      u_host.frame_end();
      check(so_oe, 1'b0, "output enable after frame");
      $display("Test read page_bin=%0d done", bin);
   endtask

   // Modify commands under write protect are dropped; protection enabling still runs.
   task automatic wp_check();
      logic [7:0] ops [8];
      int starts;
      ops = '{OP_PAGE_ERASE, OP_BLOCK_ERASE, OP_SECTOR_ERASE, OP_BUF1_PROGRAM,
         OP_BUF2_PROGRAM, OP_BYTE_PROGRAM, OP_MEM_PROG_BUF1, OP_MEM_PROG_BUF2};
      @(posedge mclk);
      wp_n <= 1'b0;
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         starts = n_start;
         u_host.frame_begin();
         u_host.send_header(ops[i], 24'h0001FF);
         repeat (8) @(posedge mclk);
         check(cmd_blocked, 1'b1, "blocked flag");
         check(n_start - starts, 0, "start on protected op");
         u_host.frame_end();
      end
      starts = n_start;
      u_host.frame_begin();
      u_host.send_header(OP_PROT_ENABLE_PRE, 24'h000000);
      repeat (8) @(posedge mclk);
      check(cmd_blocked, 1'b0, "blocked flag cleared");
      check(n_start - starts, 1, "start on protect enable");
      check(cmd_op, OP_PROT_ENABLE_PRE, "protect opcode");
      u_host.frame_end();
      @(posedge mclk);
      wp_n <= 1'b1;
      $display("Test write protect done");
   endtask

   // Pin reset in mid-read aborts the stream and holds outputs quiet while low.
   task automatic pin_reset_check();
      logic [7:0] rx;
      int i;
      @(posedge mclk);
      page_bin <= 1'b0;
      u_host.frame_begin();
      u_host.send_header(OP_LEGACY_READ, 24'h000010);
      u_host.send_dummies(DUMMY_BYTES);
      u_host.xfer_byte(8'h00, rx);
      @(posedge mclk);
      reset_n <= 1'b0;
      i = 0;
      while (so_oe !== 1'b0 && i < 8) begin
         @(posedge mclk);
         i++;
      end
      if (i >= 8) begin
         n_fail++;
         finish_test();
      end
      repeat (20) @(posedge mclk);
      check({so_oe, cmd_start, arr_req, cmd_blocked}, 4'h0, "flags in pin reset");
      check(cmd_op, 8'h00, "opcode in pin reset");
      u_host.frame_end();
      @(posedge mclk);
      reset_n <= 1'b1;
      repeat (8) @(posedge mclk);
      $display("Test pin reset done");
   endtask

   // Main sequence and a watchdog that cuts a hang short.
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      check({so_oe, cmd_start, arr_req, cmd_blocked}, 4'h0, "flags after reset");
      check({cmd_op, cmd_addr}, 32'h0, "command after reset");
      $display("Test power-on reset done");
      read_check(12'h123, LAST_BYTE_STD, 1'b0, 3);
      read_check(LAST_PAGE, LAST_BYTE_BIN, 1'b1, 3);
      wp_check();
      pin_reset_check();
      read_check(12'h7FE, 10'h001, 1'b0, 2);
      finish_test();
   end

   initial begin
      repeat (100000) @(posedge mclk);
      n_fail++;
      finish_test();
   end
endmodule
